// ---- rtl/irq_defines.svh ----
// Constants for the interrupt enable and output block
`ifndef IRQ_DEFINES_SVH
`define IRQ_DEFINES_SVH
`define IRQ_EN_OFFSET 8'h20
`define IRQ_SEL_OFFSET 8'h21
`define IRQ_EN_RESET_GND 8'h00
`define IRQ_EN_RESET_VDD 8'h20
`define IRQ_SEL_RESET 8'h00
`define BIT_SAMPLE_READY 3'd7
`define BIT_BUFFER 3'd6
`define BIT_CHANGE_OUTSIDE 3'd5
`define BIT_CHANGE_INSIDE 3'd4
`define BIT_POSTURE 3'd3
`define BIT_AUTOSLEEP 3'd2
`define BIT_BOOT 3'd1
`define BIT_WAKE_OUT 3'd0
`define CLK_PERIOD_NS 10
`define MOTION_PULSE_MS 5
`define MOTION_PULSE_CYCLES ((`MOTION_PULSE_MS * 1000000) / `CLK_PERIOD_NS)
`define SHORT_BOOT_PULSE_US 10
`define SHORT_BOOT_PULSE_CYCLES ((`SHORT_BOOT_PULSE_US * 1000) / `CLK_PERIOD_NS)
`define LONG_BOOT_PULSE_MS 5
`define LONG_BOOT_PULSE_CYCLES ((`LONG_BOOT_PULSE_MS * 1000000) / `CLK_PERIOD_NS)
`define SYS_MODE_WAKE 2'b01
`endif

// ---- rtl/irq_enable_output.sv ----
// Interrupt source enables, routing and pin drive
`timescale 1ns/10ps
`default_nettype none
`include "irq_defines.svh"
module irq_enable_output #(
  parameter int MOTION_CYCLES = `MOTION_PULSE_CYCLES,
  parameter int SHORT_BOOT_CYCLES = `SHORT_BOOT_PULSE_CYCLES,
  parameter int LONG_BOOT_CYCLES = `LONG_BOOT_PULSE_CYCLES
) (
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic power_rstn,
  input wire logic hibernate,
  input wire logic standalone_strap,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  input wire logic [7:0] irq_route,
  input wire logic irq_polarity,
  input wire logic [1:0] sys_mode,
  input wire logic active_entry,
  input wire logic odr_tick,
  input wire logic sample_ready_set,
  input wire logic data_read,
  input wire logic [6:2] source_flags,
  input wire logic boot_complete,
  output logic sample_ready_flag,
  output logic boot_done_flag,
  output logic irq_pin_first_out,
  output logic irq_pin_first_oe,
  output logic irq_pin_second_out,
  output logic irq_pin_second_oe
);
  logic [7:0] enables;
  logic boot_irq_off;
  logic strap_q;
  logic strap_seen;
  logic [7:0] active_req;
  logic [7:0] gated;
  logic req_first;
  logic req_second;
  logic wake_on;
  logic wake_now;
  logic boot_level;
  logic sample_pulse_busy;
  logic motion_busy;
  logic boot_busy;
  logic any_pending;
  logic next_first;
  logic next_second;
  irq_pkg::boot_state_t boot_state;

  pulse_timer_if sample_ctl ();
  pulse_timer_if boot_ctl ();

  // Strap caught once after reset release
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      strap_seen <= 1'b0;
      strap_q <= 1'b0;
    end else if (!strap_seen) begin
      strap_seen <= 1'b1;
      strap_q <= standalone_strap;
    end
  end

  // Enables other than boot-off; reset value depends on the strap
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      enables <= `IRQ_EN_RESET_GND;
    end else if (!strap_seen) begin
      enables <= standalone_strap ? `IRQ_EN_RESET_VDD : `IRQ_EN_RESET_GND;
    end else if (reg_wr && reg_addr == `IRQ_EN_OFFSET) begin
      enables <= reg_wdata;
    end
  end

  // Separate power-domain reset so a soft reset keeps it
  always_ff @(posedge core_clk) begin
    if (!power_rstn || hibernate) begin
      boot_irq_off <= 1'b0;
    end else if (rstn && reg_wr && reg_addr == `IRQ_EN_OFFSET) begin
      boot_irq_off <= reg_wdata[`BIT_BOOT];
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd && reg_addr == `IRQ_EN_OFFSET) begin
      reg_rdata <= {enables[7:2], boot_irq_off, enables[0]};
    end else begin
      reg_rdata <= 8'h00;
    end
  end

  // Sample-ready flag; a new sample beats a simultaneous read
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      sample_ready_flag <= 1'b0;
    end else if (sample_ready_set) begin
      sample_ready_flag <= 1'b1;
    end else if (data_read) begin
      sample_ready_flag <= 1'b0;
    end
  end

  assign sample_ctl.start = strap_q && sample_ready_set && enables[`BIT_SAMPLE_READY];
  assign sample_ctl.cut = active_entry;
  assign sample_pulse_busy = sample_ctl.busy;

  pulse_timer #(
    .CYCLES(MOTION_CYCLES)
  ) sample_timer (
    .core_clk(core_clk),
    .rstn(rstn),
    .ctl(sample_ctl)
  );

  // Boot sequence pulse; one shot per reset
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      boot_state <= irq_pkg::boot_idle;
    end else begin
      case (boot_state)
        irq_pkg::boot_idle: begin
          if (boot_complete) begin
            boot_state <= irq_pkg::boot_pulse;
          end
        end
        irq_pkg::boot_pulse: begin
          if (!boot_busy) begin
            boot_state <= irq_pkg::boot_done;
          end
        end
        default: begin
          boot_state <= irq_pkg::boot_done;
        end
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      boot_done_flag <= 1'b0;
    end else if (boot_complete) begin
      boot_done_flag <= 1'b1;
    end
  end

  // One timer serves both widths; strap fixed before boot completes
  localparam int BOOT_W = $clog2(LONG_BOOT_CYCLES + 1);
  localparam int REP_W = $clog2(MOTION_CYCLES + 1);
  logic boot_timer_busy;
  logic [BOOT_W-1:0] boot_count;
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      boot_count <= '0;
    end else if (boot_state == irq_pkg::boot_idle && boot_complete) begin
      boot_count <= strap_q ? BOOT_W'(LONG_BOOT_CYCLES)
                            : BOOT_W'(SHORT_BOOT_CYCLES);
    end else if (boot_count != '0) begin
      boot_count <= boot_count - 1'b1;
    end
  end
  assign boot_timer_busy = (boot_count != '0);
  assign boot_busy = boot_timer_busy;
  assign boot_ctl.start = 1'b0;
  assign boot_ctl.cut = 1'b0;

  // Strap high: motion pulse train at data rate while anything pending
  assign any_pending = |(gated[6:2]) || (sample_ready_flag && enables[`BIT_SAMPLE_READY]);
  assign motion_busy = boot_ctl.busy;

  pulse_timer #(
    .CYCLES(MOTION_CYCLES)
  ) motion_timer (
    .core_clk(core_clk),
    .rstn(rstn),
    .ctl(boot_ctl)
  );

  logic [REP_W-1:0] repeat_count;
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      repeat_count <= '0;
    end else if (strap_q && odr_tick && any_pending) begin
      repeat_count <= REP_W'(MOTION_CYCLES);
    end else if (repeat_count != '0) begin
      repeat_count <= repeat_count - 1'b1;
    end
  end

  // Source requests before enables
  assign active_req[`BIT_SAMPLE_READY] = strap_q ? (sample_pulse_busy || repeat_count != '0) : sample_ready_flag;
  assign active_req[6:2] = source_flags;
  assign boot_level = (boot_state == irq_pkg::boot_pulse) && boot_busy;
  assign active_req[`BIT_BOOT] = boot_level;
  assign wake_now = (sys_mode == `SYS_MODE_WAKE);
  assign active_req[`BIT_WAKE_OUT] = 1'b0;

  // Gating per source by its enable; boot by its off bit, which strap high ignores
  genvar i;
  generate
    for (i = 2; i < 8; i++) begin : g_gate
      assign gated[i] = active_req[i] && enables[i];
    end
  endgenerate
  assign gated[`BIT_BOOT] = active_req[`BIT_BOOT] && (strap_q || !boot_irq_off);
  assign gated[`BIT_WAKE_OUT] = 1'b0;
  assign wake_on = enables[`BIT_WAKE_OUT];

  // Pin combination; strap high limits second pin to boot only
  always_comb begin
    req_first = 1'b0;
    req_second = 1'b0;
    for (int k = 2; k < 8; k++) begin
      if (!irq_route[k]) begin
        req_first = req_first || (strap_q ? (gated[k] && repeat_count != '0) || (k == 7 && sample_pulse_busy && enables[7]) : gated[k]);
      end else if (!strap_q) begin
        req_second = req_second || gated[k];
      end
    end
    if (strap_q) begin
      req_second = req_second || gated[`BIT_BOOT];
    end else if (irq_route[`BIT_BOOT]) begin
      req_second = req_second || gated[`BIT_BOOT];
    end else begin
      req_first = req_first || gated[`BIT_BOOT];
    end
  end

  // Wake level overrides pin level; other sources on it are the host's concern
  always_comb begin
    // Strap high: first pin is open-drain, so its pulse must be active low
    next_first = req_first ? (strap_q ? 1'b0 : irq_polarity) : (strap_q ? 1'b1 : !irq_polarity);
    next_second = req_second ? (strap_q ? 1'b0 : irq_polarity) : (strap_q ? 1'b1 : !irq_polarity);
    if (wake_on && !irq_route[`BIT_WAKE_OUT]) begin
      next_first = wake_now ? irq_polarity : !irq_polarity;
    end else if (wake_on && irq_route[`BIT_WAKE_OUT]) begin
      next_second = wake_now ? irq_polarity : !irq_polarity;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      irq_pin_first_out <= 1'b0;
      irq_pin_second_out <= 1'b0;
    end else begin
      irq_pin_first_out <= next_first;
      irq_pin_second_out <= next_second;
    end
  end

  // Open-drain in strap-high mode: only the low level is driven
  assign irq_pin_first_oe = strap_q ? !irq_pin_first_out : 1'b1;
  assign irq_pin_second_oe = strap_q ? !irq_pin_second_out : 1'b1;
endmodule : irq_enable_output
`default_nettype wire

// ---- rtl/irq_pkg.sv ----
// Types for the interrupt enable and output block
package irq_pkg;
  typedef enum logic [2:0] {
    boot_idle = 3'b001,
    boot_pulse = 3'b010,
    boot_done = 3'b100
  } boot_state_t;
endpackage : irq_pkg

// ---- rtl/pulse_timer.sv ----
// Retriggerable one-shot pulse timer
`timescale 1ns/10ps
`default_nettype none
module pulse_timer #(
  parameter int CYCLES = 500000
) (
  input wire logic core_clk,
  input wire logic rstn,
  pulse_timer_if.timer ctl
);
  localparam int W = $clog2(CYCLES + 1);
  logic [W-1:0] count;

  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      count <= '0;
    end else if (ctl.cut) begin
      count <= '0;
    end else if (ctl.start) begin
      count <= W'(CYCLES);
    end else if (count != '0) begin
      count <= count - W'(1);
    end
  end

  assign ctl.busy = (count != '0);
endmodule : pulse_timer
`default_nettype wire

// ---- rtl/pulse_timer_if.sv ----
// Start and busy signals of a pulse timer
`timescale 1ns/10ps
`default_nettype none
interface pulse_timer_if;
  logic start;
  logic cut;
  logic busy;
  modport owner (output start, output cut, input busy);
  modport timer (input start, input cut, output busy);
endinterface : pulse_timer_if
`default_nettype wire

// ---- verification/host_pins.sv ----
// Host view of the two interrupt pins
`timescale 1ns/10ps
`default_nettype none
module host_pins (
  input wire logic first_out,
  input wire logic first_oe,
  input wire logic second_out,
  input wire logic second_oe,
  output logic first_lvl,
  output logic second_lvl
);
  // Released pin rises through its pull-up
  assign first_lvl = first_oe ? first_out : 1'b1;
  assign second_lvl = second_oe ? second_out : 1'b1;
endmodule : host_pins
`default_nettype wire

// ---- verification/irq_props.sv ----
// Checker for the interrupt enable and pin outputs
`timescale 1ns/10ps
`default_nettype none
module irq_props #(
  parameter int MOTION_CYCLES = 20,
  parameter int SHORT_BOOT_CYCLES = 5,
  parameter int LONG_BOOT_CYCLES = 20
) (
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic power_rstn,
  input wire logic hibernate,
  input wire logic standalone_strap,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  input wire logic [7:0] irq_route,
  input wire logic irq_polarity,
  input wire logic [1:0] sys_mode,
  input wire logic sample_ready_set,
  input wire logic data_read,
  input wire logic [6:2] source_flags,
  input wire logic sample_ready_flag,
  input wire logic irq_pin_first_out,
  input wire logic irq_pin_first_oe,
  input wire logic irq_pin_second_out,
  input wire logic irq_pin_second_oe
);
  // Shadow enables; boot-off bit outlives soft reset
  logic [7:0] en;
  always_ff @(posedge core_clk) begin
    if (!power_rstn || hibernate) en <= 8'h00;
    else if (!rstn) en <= {6'h00, en[1], 1'b0};
    else if (reg_wr && reg_addr == 8'h20) en <= reg_wdata;
  end
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rstn || !power_rstn || hibernate);
  sequence s_wr; reg_wr && reg_addr == 8'h20; endsequence
  sequence s_rd; reg_rd && !reg_wr && reg_addr == 8'h20; endsequence
  property p_rd_back; s_wr ##1 s_rd |=> reg_rdata == $past(reg_wdata, 2); endproperty
  a_rd_back: assert property (p_rd_back) else $error("readback wrong");
  property p_rd_other; reg_rd && reg_addr != 8'h20 |=> reg_rdata == 8'h00; endproperty
  a_rd_other: assert property (p_rd_other) else $error("other address not zero");
  property p_set; sample_ready_set |=> sample_ready_flag; endproperty
  a_set: assert property (p_set) else $error("flag not set");
  property p_clr; data_read && !sample_ready_set |=> !sample_ready_flag; endproperty
  a_clr: assert property (p_clr) else $error("flag not cleared");
  // Three cycles let the strap capture settle
  property p_oe; !standalone_strap [*3] |-> irq_pin_first_oe && irq_pin_second_oe; endproperty
  a_oe: assert property (p_oe) else $error("pin not driven");
  property p_quiet; (!standalone_strap && en == 8'h02 && $stable(irq_polarity)) [*3]
    |-> irq_pin_first_out != irq_polarity && irq_pin_second_out != irq_polarity; endproperty
  a_quiet: assert property (p_quiet) else $error("pin active while disabled");
  property p_src; (!standalone_strap && |(source_flags & en[6:2] & ~irq_route[6:2]) && !(en[0] && !irq_route[0])
    && $stable(irq_polarity)) [*3] |-> irq_pin_first_out == irq_polarity; endproperty
  a_src: assert property (p_src) else $error("source not on first pin");
  property p_wake; (!standalone_strap && en[0] && !irq_route[0] && sys_mode == 2'h1 && $stable(irq_polarity))
    [*3] |-> irq_pin_first_out == irq_polarity; endproperty
  a_wake: assert property (p_wake) else $error("wake level wrong");
  property p_leave; (!standalone_strap && en == 8'h03 && !irq_route[0] && sys_mode != 2'h1
    && $stable(irq_polarity)) [*3] |-> irq_pin_first_out != irq_polarity; endproperty
  a_leave: assert property (p_leave) else $error("sleep level wrong");
endmodule : irq_props
`default_nettype wire

// ---- verification/tb.sv ----
// Self-checking bench for the interrupt enable block
`timescale 1ns/10ps
`default_nettype none
module tb;
  localparam int SB = 5;
  localparam int LB = 20;
  logic core_clk = 0, rstn = 0, power_rstn = 0, hibernate = 0, standalone_strap = 0, reg_wr = 0, reg_rd = 0;
  logic irq_polarity = 1, active_entry = 0, odr_tick = 0, sample_ready_set = 0, data_read = 0, boot_complete = 0;
  logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, irq_route = 8'h00, reg_rdata, en, d;
  logic [1:0] sys_mode = 2'h0;
  logic [6:2] source_flags = 5'h00;
  logic sample_ready_flag, boot_done_flag, irq_pin_first_out, irq_pin_first_oe, irq_pin_second_out;
  logic irq_pin_second_oe, lvl1, lvl2;
  int fail_count = 0, num_checks = 0, n;
  always #5 core_clk = ~core_clk;
  irq_enable_output #(.MOTION_CYCLES(20), .SHORT_BOOT_CYCLES(SB), .LONG_BOOT_CYCLES(LB)) uut (.*);
  host_pins host (.first_out(irq_pin_first_out), .first_oe(irq_pin_first_oe), .second_out(irq_pin_second_out),
    .second_oe(irq_pin_second_oe), .first_lvl(lvl1), .second_lvl(lvl2));
  function automatic logic lvl_of(input logic on);
    return irq_polarity ^ !on;
  endfunction : lvl_of
  task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("[FAIL] %s exp %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic step(input int k);
    repeat (k) @(posedge core_clk);
    #1;
  endtask : step
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    reg_wr = 1;
    reg_addr = a;
    reg_wdata = v;
    step(1);
    reg_wr = 0;
  endtask : wr
  task automatic rd(input logic [7:0] a);
    reg_rd = 1;
    reg_addr = a;
    step(1);
    reg_rd = 0;
    d = reg_rdata;
  endtask : rd
  task automatic rst(input logic pwr);
    rstn = 0;
    power_rstn = !pwr;
    step(2);
    rstn = 1;
    power_rstn = 1;
    step(2);
  endtask : rst
  task automatic boot_cnt(input logic lvl, input int exp);
    boot_complete = 1;
    step(1);
    boot_complete = 0;
    n = 0;
    repeat (3 * LB) begin
      step(1);
      n += int'((standalone_strap ? lvl2 : lvl1) === lvl);
    end
    chk("boot pulse", n[7:0], exp[7:0]);
  endtask : boot_cnt
  task automatic finish_test;
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : finish_test
  initial begin
    #100000;
    fail_count++;
    finish_test;
  end
  initial begin
    void'($urandom(63426));
    rst(1);
    rd(8'h20);
    chk("enable reset", d, 8'h00);
    rd(8'h21);
    chk("unmapped read", d, 8'h00);
    repeat (40) begin
      en = {1'b0, 5'($urandom), 2'h2};
      irq_route = 8'($urandom);
      irq_polarity = 1'($urandom);
      source_flags = 5'($urandom);
      wr(8'h20, en);
      rd(8'h20);
      chk("enable readback", d, en);
      step(2);
      chk("first pin", lvl1, lvl_of(|(source_flags & en[6:2] & ~irq_route[6:2])));
      chk("second pin", lvl2, lvl_of(|(source_flags & en[6:2] & irq_route[6:2])));
    end
    $display("test sources done");
    source_flags = 5'h00;
    irq_polarity = 1;
    for (int k = 0; k < 3; k++) begin
      irq_route = {k == 2, 7'h00};
      wr(8'h20, {k != 0, 7'h02});
      sample_ready_set = 1;
      step(1);
      sample_ready_set = 0;
      step(2);
      chk("ready flag", sample_ready_flag, 8'h01);
      chk("ready pins", {lvl2, lvl1}, {lvl_of(k == 2), lvl_of(k == 1)});
      data_read = 1;
      step(1);
      data_read = 0;
      step(2);
      chk("read clears", {sample_ready_flag, lvl2, lvl1}, {1'b0, lvl_of(0), lvl_of(0)});
    end
    $display("test sample ready done");
    // No other source shares the wake pin here
    for (int k = 0; k < 4; k++) begin
      irq_polarity = k[0];
      irq_route = {7'h00, k[1]};
      wr(8'h20, 8'h03);
      sys_mode = 2'h1;
      step(3);
      chk("wake hold", {lvl2, lvl1}, {lvl_of(k[1]), lvl_of(!k[1])});
      sys_mode = 2'h2;
      step(3);
      chk("wake leave", {lvl2, lvl1}, {lvl_of(0), lvl_of(0)});
      wr(8'h20, 8'h02);
      sys_mode = 2'h1;
      step(3);
      chk("wake off", {lvl2, lvl1}, {lvl_of(0), lvl_of(0)});
    end
    $display("test wake done");
    irq_route = 8'h00;
    sys_mode = 2'h0;
    // Boot pulse fires once per reset, so each case starts from a soft reset
    for (int k = 0; k < 2; k++) begin
      irq_polarity = k[0];
      rst(0);
      wr(8'h20, 8'h00);
      boot_cnt(k[0], SB);
    end
    rst(0);
    wr(8'h20, 8'h02);
    boot_cnt(1'b1, 0);
    $display("test boot done");
    rst(0);
    rd(8'h20);
    chk("boot off kept", d, 8'h02);
    hibernate = 1;
    step(1);
    hibernate = 0;
    rd(8'h20);
    chk("hibernate clears", d, 8'h00);
    $display("test retention done");
    standalone_strap = 1;
    rst(1);
    rd(8'h20);
    chk("strap enable reset", d, 8'h20);
    boot_cnt(1'b0, LB);
    wr(8'h20, 8'hA0);
    sample_ready_set = 1;
    step(1);
    sample_ready_set = 0;
    n = 0;
    repeat (40) begin
      n += int'(lvl1 === 1'b0);
      step(1);
    end
    chk("strap ready pulse", n[7:0], 8'h14);
    sample_ready_set = 1;
    step(1);
    sample_ready_set = 0;
    active_entry = 1;
    step(1);
    active_entry = 0;
    step(1);
    chk("ready pulse cut", lvl1, 8'h01);
    odr_tick = 1;
    step(1);
    odr_tick = 0;
    step(1);
    chk("ready repeat", lvl1, 8'h00);
    data_read = 1;
    step(1);
    data_read = 0;
    chk("strap read clears", sample_ready_flag, 8'h00);
    $display("test strap done");
    finish_test;
  end
endmodule : tb
bind irq_enable_output irq_props #(.MOTION_CYCLES(MOTION_CYCLES), .SHORT_BOOT_CYCLES(SHORT_BOOT_CYCLES),
  .LONG_BOOT_CYCLES(LONG_BOOT_CYCLES)) props (.*);
`default_nettype wire
